/* hw/trace_pkg.sv */
// status codes, core event and trace entry carriers for the trace encoder
// assumes one processor clock shared by core, encoder and trace buffer
package trace_pkg;
  localparam logic [4:0] PSC_CONTINUE = 5'h00;
  localparam logic [4:0] PSC_BEGIN = 5'h01;
  localparam logic [4:0] PSC_USER_ENTRY = 5'h03;
  localparam logic [4:0] PSC_MARKER_INSTR = 5'h04;
  localparam logic [4:0] PSC_TAKEN_BRANCH = 5'h05;
  localparam logic [4:0] PSC_EXC_RETURN = 5'h07;
  localparam logic [4:0] PSC_DATA_1B = 5'h08;
  localparam logic [4:0] PSC_DATA_2B = 5'h09;
  localparam logic [4:0] PSC_DATA_4B = 5'h0B;
  localparam logic [4:0] PSC_ADDR_2B = 5'h0D;
  localparam logic [4:0] PSC_ADDR_3B = 5'h0E;
  localparam logic [4:0] PSC_RUN_BASE = 5'h12;
  localparam logic [4:0] PSC_RUN_TOP = 5'h1A;
  localparam logic [3:0] RUN_MIN = 4'h2;
  localparam logic [3:0] RUN_MAX = 4'hA;
  localparam logic [3:0] NIBS_BYTE = 4'h2;
  localparam logic [3:0] NIBS_WORD = 4'h4;
  localparam logic [3:0] NIBS_LONG = 4'h8;
  localparam logic [3:0] NIBS_ADDR2 = 4'h4;
  localparam logic [3:0] NIBS_ADDR3 = 4'h6;
  localparam int NIB_W = 4;
  localparam logic [1:0] BUF_DEPTH = 2'h2;

  typedef enum logic [2:0] {
    OP_CONTINUE = 3'h0,
    OP_BEGIN = 3'h1,
    OP_USER_ENTRY = 3'h2,
    OP_PULSE = 3'h3,
    OP_WRITE_DEBUG_DATA = 3'h4,
    OP_TAKEN = 3'h5,
    OP_PC_SYNC = 3'h6,
    OP_EXC_RETURN = 3'h7
  } core_op_e;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } op_size_e;

  localparam logic [1:0] TGT_BYTES_NONE = 2'h0;
  localparam logic [1:0] TGT_BYTES_2 = 2'h1;
  localparam logic [1:0] TGT_BYTES_3 = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MAIN = 4'h2,
    ST_MARK = 4'h4,
    ST_NIBBLE = 4'h8
  } enc_state_e;

  typedef struct packed {
    core_op_e op;
    logic indirect;
    logic [23:0] target;
    logic periph_access;
    op_size_e size;
    logic [31:0] operand;
  } core_event_s;

  typedef struct packed {
    logic is_data;
    logic [4:0] value;
  } trace_entry_s;

  localparam int ENTRY_W = $bits(trace_entry_s);
endpackage

/* hw/trace_buffer_mem.sv */
// circular trace buffer storage, one write and one registered read port
// assumes the writer wraps its own pointer
module trace_buffer_mem #(
  parameter int DEPTH = 64,
  parameter int AW = 6,
  parameter int W = 6
) (
  input wire logic clock_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [W-1:0] rd_data_o
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clock_i)
  begin
    if (wr_en_i)
    begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    rd_data_o <= mem[rd_addr_i];
  end
endmodule

/* hw/processor_status_trace_encoder.sv */
// status and debug data stream encoder with run compression and trace buffer
// assumes core holds an event while event_ready_o is low; one clock domain
// Behaviour
// - every executed instruction yields a status code, except compressible begins, which go into a run count
// - indirect flow: marker, then address nibbles
// - enabled peripheral accesses: marker, then operand nibbles
// - compress single-begin codes into one count
// - status code is five bits wide
// - later cycles of instruction emit continue
// - first cycle of ordinary instruction emits begin
// - user mode entry emits its own code
// - pulse: marker only; data write: marker, size marker, nibbles
// - data write operand always goes out
// - taken branch or pc sync emits branch code
// - exception return emits dedicated code
// - size markers for 1,2,4 bytes; no reserved
// - peripheral capture only when capture control set
// - stream is recorded into the trace buffer
// - runs 2..10 map to consecutive codes
// - address size marker, address shifted right one
module processor_status_trace_encoder
  import trace_pkg::*;
#(
  parameter int TB_DEPTH = 64,
  parameter int TB_AW = 6
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire core_event_s event_i,
  input wire logic event_valid_i,
  output logic event_ready_o,
  input wire logic compress_en_i,
  input wire logic data_capture_control_i,
  input wire logic [1:0] branch_target_bytes_control_i,
  output trace_entry_s trace_o,
  output logic trace_valid_o,
  input wire logic trace_ready_i,
  input wire logic [TB_AW-1:0] tb_rd_addr_i,
  output logic [ENTRY_W-1:0] tb_rd_data_o,
  output logic [TB_AW-1:0] tb_wr_ptr_o
);
  function automatic logic [4:0] run_code(input logic [3:0] n);
    if (n == 4'h1)
      return PSC_BEGIN;
    return PSC_RUN_BASE + 5'(n - RUN_MIN);
  endfunction

  function automatic logic [4:0] size_marker(input op_size_e s);
    case (s)
      SIZE_BYTE: return PSC_DATA_1B;
      SIZE_WORD: return PSC_DATA_2B;
      default: return PSC_DATA_4B;
    endcase
  endfunction

  function automatic logic [3:0] size_nibs(input op_size_e s);
    case (s)
      SIZE_BYTE: return NIBS_BYTE;
      SIZE_WORD: return NIBS_WORD;
      default: return NIBS_LONG;
    endcase
  endfunction

  enc_state_e state;
  enc_state_e next_state;
  logic [3:0] run;
  logic [4:0] lat_main;
  logic lat_has_pay;
  logic [4:0] lat_marker;
  logic [3:0] lat_nibs;
  logic [31:0] lat_data;
  logic [3:0] nib_idx;
  trace_entry_s slot1;
  logic valid1;
  logic acc;
  logic push;
  logic pop;
  logic buf_in_ready;
  trace_entry_s push_entry;
  logic [1:0] next_count;
  logic [4:0] ev_main;
  logic ev_has_pay;
  logic [4:0] ev_marker;
  logic [3:0] ev_nibs;
  logic [31:0] ev_data;
  logic compressible;
  logic flush;
  logic [TB_AW-1:0] wr_ptr;

  assign acc = event_valid_i && event_ready_o;
  assign pop = trace_valid_o && trace_ready_i;
  // a slot frees up in the same cycle as a pop, so a full buffer still flows
  assign buf_in_ready = !valid1 || pop;

  // main code and optional payload of the offered event
  always_comb
  begin
    ev_has_pay = 1'b0;
    ev_marker = size_marker(event_i.size);
    ev_nibs = size_nibs(event_i.size);
    ev_data = event_i.operand;
    case (event_i.op)
      OP_CONTINUE: ev_main = PSC_CONTINUE;
      OP_BEGIN: ev_main = PSC_BEGIN;
      OP_USER_ENTRY: ev_main = PSC_USER_ENTRY;
      OP_PULSE: ev_main = PSC_MARKER_INSTR;
      OP_WRITE_DEBUG_DATA: ev_main = PSC_MARKER_INSTR;
      OP_TAKEN: ev_main = PSC_TAKEN_BRANCH;
      OP_PC_SYNC: ev_main = PSC_TAKEN_BRANCH;
      OP_EXC_RETURN: ev_main = PSC_EXC_RETURN;
      default: ev_main = PSC_BEGIN;
    endcase
    if (event_i.op == OP_WRITE_DEBUG_DATA)
    begin
      ev_has_pay = 1'b1;
    end
    else if ((event_i.op == OP_TAKEN && event_i.indirect) || event_i.op == OP_PC_SYNC)
    begin
      // address goes out halved: bit 0 is always zero for instructions
      ev_has_pay = (branch_target_bytes_control_i != TGT_BYTES_NONE);
      ev_data = {8'h00, 1'b0, event_i.target[23:1]};
      if (branch_target_bytes_control_i == TGT_BYTES_3)
      begin
        ev_marker = PSC_ADDR_3B;
        ev_nibs = NIBS_ADDR3;
      end
      else
      begin
        ev_marker = PSC_ADDR_2B;
        ev_nibs = NIBS_ADDR2;
      end
    end
    else if (event_i.periph_access && data_capture_control_i)
    begin
      ev_has_pay = 1'b1;
    end
  end

  // captured data always flushes the run, so a payload event never compresses
  assign compressible = compress_en_i && event_i.op == OP_BEGIN && !ev_has_pay;
  assign flush = (run != 4'h0) && !compressible;

  always_comb
  begin
    push = 1'b0;
    push_entry = '{is_data: 1'b0, value: PSC_CONTINUE};
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (acc && flush)
        begin
          push = 1'b1;
          push_entry.value = run_code(run);
          next_state = ST_MAIN;
        end
        else if (acc && compressible)
        begin
          push = (run == RUN_MAX - 4'h1);
          push_entry.value = run_code(RUN_MAX);
        end
        else if (acc)
        begin
          push = 1'b1;
          push_entry.value = ev_main;
          next_state = ev_has_pay ? ST_MARK : ST_IDLE;
        end
      end
      ST_MAIN:
      begin
        push = buf_in_ready;
        push_entry.value = lat_main;
        if (buf_in_ready)
          next_state = lat_has_pay ? ST_MARK : ST_IDLE;
      end
      ST_MARK:
      begin
        push = buf_in_ready;
        push_entry.value = lat_marker;
        if (buf_in_ready)
          next_state = ST_NIBBLE;
      end
      ST_NIBBLE:
      begin
        push = buf_in_ready;
        push_entry.is_data = 1'b1;
        push_entry.value = {1'b0, lat_data[nib_idx*NIB_W +: NIB_W]};
        if (buf_in_ready && nib_idx == lat_nibs - 4'h1)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      run <= 4'h0;
    else if (acc && flush)
      run <= 4'h0;
    else if (acc && compressible)
      run <= (run == RUN_MAX - 4'h1) ? 4'h0 : run + 4'h1;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      lat_main <= PSC_CONTINUE;
      lat_has_pay <= 1'b0;
      lat_marker <= PSC_DATA_1B;
      lat_nibs <= NIBS_BYTE;
      lat_data <= 32'h0000_0000;
    end
    else if (acc)
    begin
      lat_main <= ev_main;
      lat_has_pay <= ev_has_pay;
      lat_marker <= ev_marker;
      lat_nibs <= ev_nibs;
      lat_data <= ev_data;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i || acc)
      nib_idx <= 4'h0;
    else if (state == ST_NIBBLE && push)
      nib_idx <= nib_idx + 4'h1; // least significant nibble first
  end

  // two-entry buffer; head slot drives the stream outputs directly
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      trace_o <= '{is_data: 1'b0, value: PSC_CONTINUE};
      trace_valid_o <= 1'b0;
      slot1 <= '{is_data: 1'b0, value: PSC_CONTINUE};
      valid1 <= 1'b0;
    end
    else if (pop)
    begin
      trace_o <= valid1 ? slot1 : push_entry;
      trace_valid_o <= valid1 || push;
      slot1 <= push_entry;
      valid1 <= valid1 && push;
    end
    else if (push && !trace_valid_o)
    begin
      trace_o <= push_entry;
      trace_valid_o <= 1'b1;
    end
    else if (push)
    begin
      slot1 <= push_entry;
      valid1 <= 1'b1;
    end
  end

  assign next_count = {1'b0, trace_valid_o} + {1'b0, valid1} + {1'b0, push} - {1'b0, pop};

  // registered ready promises room for one push in the cycle it is seen high
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      event_ready_o <= 1'b0;
    else
      event_ready_o <= (next_state == ST_IDLE) && (next_count < BUF_DEPTH);
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      wr_ptr <= '0;
    else if (pop)
      wr_ptr <= wr_ptr + 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      tb_wr_ptr_o <= '0;
    else
      tb_wr_ptr_o <= pop ? wr_ptr + 1'b1 : wr_ptr;
  end

  trace_buffer_mem #(
    .DEPTH(TB_DEPTH),
    .AW(TB_AW),
    .W(ENTRY_W)
  ) u_mem (
    .clock_i(clock_i),
    .wr_en_i(pop),
    .wr_addr_i(wr_ptr),
    .wr_data_i(trace_o),
    .rd_addr_i(tb_rd_addr_i),
    .rd_data_o(tb_rd_data_o)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  property p_one_per_instr;
    acc && !compressible |-> push;
  endproperty
  a_one_per_instr:
    assert property (p_one_per_instr) else $error("instruction produced no entry");

  property p_no_reserved;
    push && !push_entry.is_data |-> !(push_entry.value inside
      {5'h02, 5'h06, 5'h0A, 5'h0C, 5'h0F, 5'h10, 5'h11}) && push_entry.value <= PSC_RUN_TOP;
  endproperty
  a_no_reserved:
    assert property (p_no_reserved) else $error("reserved status code emitted");

  property p_run_top;
    state == ST_IDLE && acc && compressible && run == RUN_MAX - 4'h1
      |-> push && push_entry.value == PSC_RUN_TOP ##1 run == 4'h0;
  endproperty
  a_run_top:
    assert property (p_run_top) else $error("full run not flushed as top code");

  property p_single_flush;
    acc && flush && run == 4'h1 |-> push_entry.value == PSC_BEGIN ##1 state == ST_MAIN;
  endproperty
  a_single_flush:
    assert property (p_single_flush) else $error("run of one not flushed as begin");

  property p_write_data_seq;
    acc && !flush && event_i.op == OP_WRITE_DEBUG_DATA
      |-> push_entry.value == PSC_MARKER_INSTR ##1 state == ST_MARK && lat_has_pay;
  endproperty
  a_write_data_seq:
    assert property (p_write_data_seq) else $error("data write marker sequence wrong");

  property p_capture_gate;
    acc && !data_capture_control_i && event_i.op == OP_BEGIN |=> !lat_has_pay;
  endproperty
  a_capture_gate:
    assert property (p_capture_gate) else $error("capture while disabled");

  property p_rte_code;
    acc && !flush && event_i.op == OP_EXC_RETURN |-> push && push_entry.value == PSC_EXC_RETURN;
  endproperty
  a_rte_code:
    assert property (p_rte_code) else $error("exception return code missing");

  property p_addr3;
    acc && event_i.op == OP_PC_SYNC && branch_target_bytes_control_i == TGT_BYTES_3
      |=> lat_marker == PSC_ADDR_3B && lat_nibs == NIBS_ADDR3
      && lat_data[22:0] == $past(event_i.target[23:1]);
  endproperty
  a_addr3:
    assert property (p_addr3) else $error("3-byte address marker or shift wrong");

  property p_record;
    pop |=> tb_wr_ptr_o == $past(wr_ptr) + 1'b1;
  endproperty
  a_record:
    assert property (p_record) else $error("accepted entry not recorded");

  property p_nibble_end;
    state == ST_NIBBLE && push && nib_idx == lat_nibs - 4'h1 |=> state == ST_IDLE;
  endproperty
  a_nibble_end:
    assert property (p_nibble_end) else $error("nibble count wrong");

  c_run_top: cover property (acc && compressible && run == RUN_MAX - 4'h1);
  c_write_data: cover property (state == ST_NIBBLE && lat_main == PSC_MARKER_INSTR);
  c_branch_addr: cover property (state == ST_MARK && lat_main == PSC_TAKEN_BRANCH);
  c_stall: cover property (trace_valid_o && !trace_ready_i && valid1);
endmodule

/* tb/trace_sink.sv */
// downstream consumer of the trace stream, keeps every popped entry
// assumes one clock with the encoder; stall_i holds off every pop
module trace_sink
  import trace_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire trace_entry_s trace_i,
  input wire logic valid_i,
  input wire logic stall_i,
  output logic ready_o
);
  timeunit 1ns;
  timeprecision 1ns;
  trace_entry_s got[$];
  // no pop during reset so nothing stale is logged
  assign ready_o = !stall_i && !reset_i;
  always @(posedge clock_i)
  begin
    if (!reset_i && valid_i && ready_o)
    begin
      got.push_back(trace_i);
    end
  end
endmodule

/* tb/processor_status_trace_encoder_bench.sv */
// self-checking bench for the trace encoder, core side driven by tasks
// assumes trace_sink as the stream consumer and an 8-entry trace buffer
module processor_status_trace_encoder_bench
  import trace_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i;
  logic reset_i;
  core_event_s event_i;
  logic event_valid_i;
  logic event_ready;
  logic compress_en;
  logic capture_en;
  logic [1:0] tgt_bytes;
  trace_entry_s trace;
  logic trace_valid;
  logic trace_ready;
  logic stall;
  logic [2:0] rd_addr;
  logic [ENTRY_W-1:0] rd_data;
  logic [2:0] wr_ptr;
  trace_entry_s exp[$];
  int n_fail;
  int comparisons;
  int seen;

  processor_status_trace_encoder #(.TB_DEPTH(8), .TB_AW(3)) uut (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .event_i(event_i),
    .event_valid_i(event_valid_i),
    .event_ready_o(event_ready),
    .compress_en_i(compress_en),
    .data_capture_control_i(capture_en),
    .branch_target_bytes_control_i(tgt_bytes),
    .trace_o(trace),
    .trace_valid_o(trace_valid),
    .trace_ready_i(trace_ready),
    .tb_rd_addr_i(rd_addr),
    .tb_rd_data_o(rd_data),
    .tb_wr_ptr_o(wr_ptr)
  );

  trace_sink sink (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .trace_i(trace),
    .valid_i(trace_valid),
    .stall_i(stall),
    .ready_o(trace_ready)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  task automatic end_sim();
    $display("fails %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] want, input string what);
    comparisons++;
    if (got !== want)
    begin
      n_fail++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  function automatic core_event_s ev(core_op_e op, logic ind, logic [23:0] t, logic per,
                                     op_size_e sz, logic [31:0] d);
    ev = '{op, ind, t, per, sz, d};
  endfunction

  task automatic code(input logic [4:0] c);
    exp.push_back('{1'b0, c});
  endtask

  task automatic nibs(input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++)
      exp.push_back('{1'b1, {1'b0, v[4*i+:4]}});
  endtask

  // valid stays up between back-to-back sends; drain lowers it
  task automatic send(input core_event_s e);
    int k;
    event_i <= e;
    event_valid_i <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clock_i);
      k++;
    end
    while (event_ready !== 1'b1 && k < 100);
  endtask

  task automatic drain();
    int k;
    event_valid_i <= 1'b0;
    k = 0;
    while (sink.got.size() < exp.size() && k < 300)
    begin
      @(posedge clock_i);
      k++;
    end
    repeat (2) @(posedge clock_i);
    chk(8'(sink.got.size()), 8'(exp.size()), "count");
    for (int i = seen; i < exp.size() && i < sink.got.size(); i++)
    begin
      chk({2'h0, sink.got[i]}, {2'h0, exp[i]}, "entry");
      chk(8'(!sink.got[i].is_data && sink.got[i].value inside {5'h02, 5'h06, 5'h0A}),
          8'h00, "reserved");
    end
    seen = exp.size();
    chk({5'h0, wr_ptr}, 8'(exp.size() % 8), "wr_ptr");
    rd_addr <= 3'(exp.size() - 1);
    repeat (2) @(posedge clock_i);
    chk({2'h0, rd_data}, {2'h0, exp[$]}, "mem");
  endtask

  task automatic t_plain();
    compress_en <= 1'b0;
    send(ev(OP_BEGIN, 0, 0, 0, SIZE_BYTE, 0));
    code(PSC_BEGIN);
    send(ev(OP_CONTINUE, 0, 0, 0, SIZE_BYTE, 0));
    code(PSC_CONTINUE);
    send(ev(OP_USER_ENTRY, 0, 0, 0, SIZE_BYTE, 0));
    code(PSC_USER_ENTRY);
    send(ev(OP_EXC_RETURN, 0, 0, 0, SIZE_BYTE, 0));
    code(PSC_EXC_RETURN);
    send(ev(OP_TAKEN, 1, 24'h123456, 0, SIZE_BYTE, 0));
    code(PSC_TAKEN_BRANCH);
    send(ev(OP_PC_SYNC, 0, 24'h123456, 0, SIZE_BYTE, 0));
    code(PSC_TAKEN_BRANCH);
    drain();
  endtask

  // run of n begins, then a flushing event
  task automatic t_runs();
    int r;
    compress_en <= 1'b1;
    for (int n = 1; n <= 11; n++)
    begin
      repeat (n) send(ev(OP_BEGIN, 0, 0, 0, SIZE_BYTE, 0));
      send(ev(OP_EXC_RETURN, 0, 0, 0, SIZE_BYTE, 0));
      r = n;
      if (r >= 10)
      begin
        code(5'h1A);
        r -= 10;
      end
      if (r == 1)
        code(5'h01);
      else if (r > 1)
        code(5'(5'h12 + r - 2));
      code(PSC_EXC_RETURN);
      drain();
    end
    repeat (3) send(ev(OP_BEGIN, 0, 0, 0, SIZE_BYTE, 0));
    send(ev(OP_CONTINUE, 0, 0, 0, SIZE_BYTE, 0));
    code(5'h13);
    code(5'h00);
    drain();
  endtask

  task automatic t_data();
    logic [4:0] mk[3];
    int nn[3];
    mk = '{5'h08, 5'h09, 5'h0B};
    nn = '{2, 4, 8};
    compress_en <= 1'b1;
    capture_en <= 1'b0;
    for (int s = 0; s < 3; s++)
    begin
      repeat (2) send(ev(OP_BEGIN, 0, 0, 0, SIZE_BYTE, 0));
      send(ev(OP_WRITE_DEBUG_DATA, 0, 0, 0, op_size_e'(s), 32'h87654321));
      code(5'h12);
      code(5'h04);
      code(mk[s]);
      nibs(32'h87654321, nn[s]);
      drain();
    end
    send(ev(OP_PULSE, 0, 0, 0, SIZE_BYTE, 0));
    code(5'h04);
    drain();
    // receiver stall fills the two-entry buffer mid burst
    stall <= 1'b1;
    send(ev(OP_WRITE_DEBUG_DATA, 0, 0, 0, SIZE_LONG, 32'hFEDCBA98));
    repeat (6) @(posedge clock_i);
    chk({7'h0, trace_valid}, 8'h01, "stall valid");
    chk({7'h0, event_ready}, 8'h00, "stall ready");
    stall <= 1'b0;
    code(5'h04);
    code(5'h0B);
    nibs(32'hFEDCBA98, 8);
    drain();
  endtask

  task automatic t_branch();
    compress_en <= 1'b0;
    for (int b = 1; b <= 3; b++)
    begin
      tgt_bytes <= 2'(b);
      send(ev(OP_TAKEN, 1, 24'hABCDEF, 0, SIZE_BYTE, 0));
      code(5'h05);
      code(b == 2 ? 5'h0E : 5'h0D);
      nibs(32'h00ABCDEF >> 1, b == 2 ? 6 : 4);
      drain();
    end
    tgt_bytes <= 2'h2;
    send(ev(OP_PC_SYNC, 0, 24'h5A5A5B, 0, SIZE_BYTE, 0));
    code(5'h05);
    code(5'h0E);
    nibs(32'h005A5A5B >> 1, 6);
    send(ev(OP_TAKEN, 0, 24'h5A5A5B, 0, SIZE_BYTE, 0));
    code(5'h05);
    drain();
    tgt_bytes <= 2'h0;
  endtask

  task automatic t_periph();
    compress_en <= 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      capture_en <= 1'(c);
      send(ev(OP_BEGIN, 0, 0, 1, SIZE_WORD, 32'h0000BEEF));
      code(5'h01);
      if (c == 1)
      begin
        code(5'h09);
        nibs(32'h0000BEEF, 4);
      end
      send(ev(OP_BEGIN, 0, 0, 0, SIZE_WORD, 32'h0000BEEF));
      code(5'h01);
      drain();
    end
  endtask

  initial
  begin
    #200000;
    n_fail++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  initial
  begin
    reset_i = 1'b1;
    event_i = '0;
    event_valid_i = 1'b0;
    compress_en = 1'b0;
    capture_en = 1'b0;
    tgt_bytes = 2'h0;
    stall = 1'b0;
    rd_addr = 3'h0;
    n_fail = 0;
    comparisons = 0;
    seen = 0;
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    chk({7'h0, trace_valid}, 8'h00, "reset valid");
    chk({5'h0, wr_ptr}, 8'h00, "reset ptr");
    t_plain();
    t_runs();
    t_data();
    t_branch();
    t_periph();
    end_sim();
  end
endmodule
